// >>> shared/scq_pkg.sv
// Constants and types shared by the scan sequencer timing block.
package scq_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0] SCQ_ADDR_SETUP = 4'h1;
	localparam logic [3:0] SCQ_ADDR_SCAN = 4'h7;
	localparam logic [3:0] SCQ_ADDR_TIMER = 4'h8;
	localparam logic [23:0] SCQ_SCAN_RST = 24'h000000;
	localparam logic [23:0] SCQ_TIMER_RST = 24'h000000;

	// ----------------------------------------------------------------
	// Field layout of the scan channel config register and of the output data tag
	// ----------------------------------------------------------------
	localparam int SCQ_DLY_LSB = 20;
	localparam int SCQ_DLY_MSB = 22;
	localparam int SCQ_EN_MSB = 15;
	localparam int SCQ_TAG_LSB = 20;

	// ----------------------------------------------------------------
	// Converter modes, gains, formats
	// ----------------------------------------------------------------
	localparam logic [1:0] SCQ_MODE_SHUT = 2'h0;
	localparam logic [1:0] SCQ_MODE_STBY = 2'h2;
	localparam logic [1:0] SCQ_MODE_CONV = 2'h3;
	localparam logic [2:0] SCQ_GAIN_THIRD = 3'h0;
	localparam logic [2:0] SCQ_GAIN_ONE = 3'h3;
	localparam logic [1:0] SCQ_FMT_TAGGED = 2'h3;

	// ----------------------------------------------------------------
	// Channel indices and forced multiplexer codes
	// ----------------------------------------------------------------
	localparam logic [3:0] SCQ_CH_OFFSET = 4'hf;
	localparam logic [3:0] SCQ_CH_VCM = 4'he;
	localparam logic [3:0] SCQ_CH_SUPPLY = 4'hd;
	localparam logic [3:0] SCQ_CH_TEMP = 4'hc;
	localparam logic [7:0] SCQ_MUX_OFFSET = 8'h88;
	localparam logic [7:0] SCQ_MUX_VCM = 8'hf8;
	localparam logic [7:0] SCQ_MUX_SUPPLY = 8'h98;
	localparam logic [7:0] SCQ_MUX_TEMP = 8'hde;
	localparam logic [7:0] SCQ_MUX_DIFF_D = 8'h67;
	localparam logic [7:0] SCQ_MUX_DIFF_C = 8'h45;
	localparam logic [7:0] SCQ_MUX_DIFF_B = 8'h23;
	localparam logic [7:0] SCQ_MUX_DIFF_A = 8'h01;
	localparam logic [3:0] SCQ_MUX_SE_LOW = 4'h8;

	// ----------------------------------------------------------------
	// Timing in decimated clock periods
	// ----------------------------------------------------------------
	localparam logic [23:0] SCQ_SETUP_PERIODS = 24'h000100;
	localparam logic [9:0] SCQ_DLY_BASE = 10'h008;

	typedef enum logic [4:0] {
		SCQ_IDLE = 5'b00001,
		SCQ_CONV = 5'b00010,
		SCQ_DELAY = 5'b00100,
		SCQ_GAP = 5'b01000,
		SCQ_SPARE = 5'b10000
	} scq_state_t;

endpackage

// >>> design/scq_scan_sequencer.sv
// Scan sequencer: channel order, monitor overrides, intra and inter cycle timing.
//
// Behaviour
// - Supply channel: mux 0x98, gain one third
// - Overrides never alter stored register contents
// - Temperature channel: mux 0xde, unity gain
// - Offset channel shorts mux output to ground
// - Common-mode channel: mux 0xf8, unity gain
// - Delay code held in scan register 22:20
// - Delay codes map to 0,8..512 periods
// - Delay only between conversions of one cycle
// - Delay: internal standby, reads back 11
// - Mux switches to next input at conversion end
// - Continuous mode repeats cycles after timer gap
// - Gap equals timer value in periods
// - Counter decrements to zero, then cycle launches
// - Gap above 256: shutdown at cycle end
// - Shutdown case: power up at count 256
// - Gap below setup time: standby between cycles
// - Mode field reads 11 throughout scanning
// - Channels converted from highest enable bit down
// - Each conversion updates data and pulses ready
// - Tagged format puts channel tag in MSBs
module scq_scan_sequencer
	import scq_pkg::*;
(
	input wire logic mclk, // 250 MHz clock
	input wire logic rst_n, // Async reset, active low
	input wire logic dmclkTick, // One pulse per decimated clock period
	input wire logic regWrEn, // Register write strobe
	input wire logic [3:0] regAddr, // Register address
	input wire logic [23:0] regWrData, // Register write data
	output logic [23:0] regRdData, // Register read data
	input wire logic startScan, // Pulse: start scan sequence
	input wire logic continuous, // Continuous conversion mode
	input wire logic [2:0] gainSel, // Programmed gain select
	input wire logic [1:0] dataFormat, // Output format code
	input wire logic convDone, // Pulse: converter finished
	input wire logic [23:0] convData, // Converter result
	output logic convStart, // Pulse: begin a conversion
	output logic [7:0] muxCode, // Multiplexer code
	output logic [2:0] gainCode, // Effective converter gain
	output logic shortToGround, // Short mux output to ground
	output logic [1:0] adcModeInt, // Internal converter state
	output logic [23:0] dataOut, // Output data register
	output logic dataReady, // Pulse: new data
	output logic scanActive // Scan sequence running
);

	typedef struct packed {
		scq_state_t state;
		logic [3:0] ch;
		logic [23:0] cnt;
		logic [23:0] scanReg;
		logic [23:0] timerReg;
		logic [1:0] mode;
		logic [23:0] data;
		logic rdy;
		logic start;
	} scq_regs_t;

	scq_regs_t r_q, r_d;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [4:0] nextCh(input logic [15:0] en, input logic [4:0] below);
		logic [4:0] res;
		res = 5'h10;
		for (int i = 0; i < 16; i++) begin
			if (en[i] && (5'(i) < below)) begin
				res = 5'(i);
			end
		end
		return res;
	endfunction

	function automatic logic [23:0] dlyPeriods(input logic [2:0] code);
		logic [23:0] res;
		res = 24'h000000;
		if (code != 3'h0) begin
			res = {14'h0, SCQ_DLY_BASE << (code - 3'h1)};
		end
		return res;
	endfunction

	function automatic logic [7:0] chMux(input logic [3:0] ch);
		logic [7:0] res;
		case (ch)
			SCQ_CH_OFFSET: res = SCQ_MUX_OFFSET;
			SCQ_CH_VCM: res = SCQ_MUX_VCM;
			SCQ_CH_SUPPLY: res = SCQ_MUX_SUPPLY;
			SCQ_CH_TEMP: res = SCQ_MUX_TEMP;
			4'hb: res = SCQ_MUX_DIFF_D;
			4'ha: res = SCQ_MUX_DIFF_C;
			4'h9: res = SCQ_MUX_DIFF_B;
			4'h8: res = SCQ_MUX_DIFF_A;
			default: res = {1'b0, ch[2:0], SCQ_MUX_SE_LOW};
		endcase
		return res;
	endfunction

	logic [15:0] enMask;
	logic [4:0] following;
	logic [4:0] first;
	assign enMask = r_q.scanReg[SCQ_EN_MSB:0];
	assign following = nextCh(enMask, {1'b0, r_q.ch});
	assign first = nextCh(enMask, 5'h10);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		r_d = r_q;
		r_d.rdy = 1'b0;
		r_d.start = 1'b0;
		if (regWrEn && regAddr == SCQ_ADDR_SCAN) begin
			r_d.scanReg = regWrData;
		end
		if (regWrEn && regAddr == SCQ_ADDR_TIMER) begin
			r_d.timerReg = regWrData;
		end
		case (r_q.state)
			SCQ_IDLE: begin
				if (startScan && !first[4]) begin
					r_d.state = SCQ_CONV;
					r_d.ch = first[3:0];
					r_d.mode = SCQ_MODE_CONV;
					r_d.start = 1'b1;
				end
			end
			SCQ_CONV: begin
				if (convDone) begin
					r_d.rdy = 1'b1;
					r_d.data = convData;
					if (dataFormat == SCQ_FMT_TAGGED) begin
						r_d.data[23:SCQ_TAG_LSB] = r_q.ch;
					end
					if (!following[4]) begin
						r_d.ch = following[3:0];
						r_d.cnt = dlyPeriods(r_q.scanReg[SCQ_DLY_MSB:SCQ_DLY_LSB]);
						r_d.state = SCQ_DELAY;
						r_d.mode = SCQ_MODE_STBY;
					end else if (continuous && !first[4]) begin
						r_d.ch = first[3:0];
						r_d.cnt = r_q.timerReg;
						r_d.state = SCQ_GAP;
						if (r_q.timerReg > SCQ_SETUP_PERIODS) begin
							r_d.mode = SCQ_MODE_SHUT;
						end else begin
							r_d.mode = SCQ_MODE_STBY;
						end
					end else begin
						r_d.state = SCQ_IDLE;
						r_d.mode = SCQ_MODE_STBY;
					end
				end
			end
			SCQ_DELAY, SCQ_GAP: begin
				if (r_q.cnt == 24'h000000) begin
					r_d.state = SCQ_CONV;
					r_d.mode = SCQ_MODE_CONV;
					r_d.start = 1'b1;
				end else if (dmclkTick) begin
					r_d.cnt = r_q.cnt - 24'h000001;
					if (r_q.state == SCQ_GAP && r_q.cnt == SCQ_SETUP_PERIODS + 24'h000001) begin
						r_d.mode = SCQ_MODE_CONV;
					end
				end
			end
			default: begin
				r_d.state = SCQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			r_q.state <= SCQ_IDLE;
			r_q.ch <= 4'h0;
			r_q.cnt <= 24'h000000;
			r_q.scanReg <= SCQ_SCAN_RST;
			r_q.timerReg <= SCQ_TIMER_RST;
			r_q.mode <= SCQ_MODE_SHUT;
			r_q.data <= 24'h000000;
			r_q.rdy <= 1'b0;
			r_q.start <= 1'b0;
		end else begin
			r_q <= r_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	logic inConv;
	assign inConv = (r_q.state == SCQ_CONV);
	assign scanActive = (r_q.state != SCQ_IDLE);
	assign convStart = r_q.start;
	assign dataOut = r_q.data;
	assign dataReady = r_q.rdy;
	assign adcModeInt = r_q.mode;
	assign muxCode = chMux(r_q.ch);
	assign shortToGround = inConv && r_q.ch == SCQ_CH_OFFSET;

	// Override only the driven gain; the programmed field is left alone
	always_comb begin
		gainCode = gainSel;
		if (inConv && r_q.ch == SCQ_CH_SUPPLY) begin
			gainCode = SCQ_GAIN_THIRD;
		end else if (inConv && (r_q.ch == SCQ_CH_TEMP || r_q.ch == SCQ_CH_VCM)) begin
			gainCode = SCQ_GAIN_ONE;
		end
	end

	always_comb begin
		case (regAddr)
			SCQ_ADDR_SCAN: regRdData = r_q.scanReg;
			SCQ_ADDR_TIMER: regRdData = r_q.timerReg;
			SCQ_ADDR_SETUP: regRdData = {22'h0, scanActive ? SCQ_MODE_CONV : r_q.mode};
			default: regRdData = 24'h000000;
		endcase
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_convSupply;
		inConv && r_q.ch == SCQ_CH_SUPPLY;
	endsequence

	property p_supply;
		@(posedge mclk) disable iff (!rst_n)
		s_convSupply |-> muxCode == SCQ_MUX_SUPPLY && gainCode == SCQ_GAIN_THIRD;
	endproperty
	a_supply: assert property (p_supply) else $error("supply override wrong");

	property p_temp;
		@(posedge mclk) disable iff (!rst_n)
		inConv && r_q.ch == SCQ_CH_TEMP |-> muxCode == SCQ_MUX_TEMP && gainCode == SCQ_GAIN_ONE;
	endproperty
	a_temp: assert property (p_temp) else $error("temperature override wrong");

	property p_vcm;
		@(posedge mclk) disable iff (!rst_n)
		inConv && r_q.ch == SCQ_CH_VCM |-> muxCode == SCQ_MUX_VCM && gainCode == SCQ_GAIN_ONE;
	endproperty
	a_vcm: assert property (p_vcm) else $error("common-mode override wrong");

	property p_short;
		@(posedge mclk) disable iff (!rst_n)
		shortToGround |-> inConv && r_q.ch == SCQ_CH_OFFSET;
	endproperty
	a_short: assert property (p_short) else $error("ground short outside offset");

	property p_keep;
		@(posedge mclk) disable iff (!rst_n)
		regWrEn && regAddr == SCQ_ADDR_SCAN |=> r_q.scanReg == $past(regWrData);
	endproperty
	a_keep: assert property (p_keep) else $error("scan register not as written");

	property p_readback;
		@(posedge mclk) disable iff (!rst_n)
		scanActive && regAddr == SCQ_ADDR_SETUP |-> regRdData[1:0] == SCQ_MODE_CONV;
	endproperty
	a_readback: assert property (p_readback) else $error("mode readback not 11");

	property p_delayStby;
		@(posedge mclk) disable iff (!rst_n)
		r_q.state == SCQ_DELAY |-> adcModeInt == SCQ_MODE_STBY;
	endproperty
	a_delayStby: assert property (p_delayStby) else $error("delay not in standby");

	sequence s_done;
		inConv && convDone;
	endsequence

	property p_ready;
		@(posedge mclk) disable iff (!rst_n)
		s_done |=> dataReady && dataOut[19:0] == $past(convData[19:0]);
	endproperty
	a_ready: assert property (p_ready) else $error("data ready missing");

	property p_gapMode;
		@(posedge mclk) disable iff (!rst_n)
		s_done ##1 r_q.state == SCQ_GAP |->
			adcModeInt == (r_q.timerReg > SCQ_SETUP_PERIODS ? SCQ_MODE_SHUT : SCQ_MODE_STBY);
	endproperty
	a_gapMode: assert property (p_gapMode) else $error("gap power state wrong");

	property p_launch;
		@(posedge mclk) disable iff (!rst_n)
		r_q.state == SCQ_GAP && r_q.cnt == 24'h000000 |=> convStart && inConv;
	endproperty
	a_launch: assert property (p_launch) else $error("cycle did not launch");

	property p_first;
		@(posedge mclk) disable iff (!rst_n)
		r_q.state == SCQ_IDLE && startScan && !first[4] |=> convStart && inConv;
	endproperty
	a_first: assert property (p_first) else $error("first conversion delayed");

	property p_wake;
		@(posedge mclk) disable iff (!rst_n)
		r_q.state == SCQ_GAP && r_q.cnt <= SCQ_SETUP_PERIODS |-> adcModeInt != SCQ_MODE_SHUT;
	endproperty
	a_wake: assert property (p_wake) else $error("converter still shut near launch");

endmodule

// >>> bench/scq_conv_model.sv
// Converter model that answers every conversion start after a fixed latency.
module scq_conv_model #(
	parameter int LAT = 6
) (
	input wire logic mclk, // Clock
	input wire logic rst_n, // Async reset, active low
	input wire logic convStart, // Conversion request
	input wire logic [7:0] muxCode, // Selected input
	output logic convDone, // End of conversion pulse
	output logic [23:0] convData // Result, valid with convDone only
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			convDone <= 1'b0;
			convData <= 24'h0;
		end else begin
			convDone <= (cnt == 1);
			if (convStart) begin
				cnt <= LAT;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
			end
			// Toggle outside the done pulse so a stale result is never taken for a fresh one
			convData <= (cnt == 1) ? {16'h5a5, muxCode} : ~convData;
		end
	end
endmodule

// >>> bench/tb_adc_scan_sequencer_timing.sv
// Self-checking bench for the scan sequencer timing block.
module tb_adc_scan_sequencer_timing
	import scq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] MUXS[5] = '{SCQ_MUX_OFFSET, SCQ_MUX_VCM, SCQ_MUX_SUPPLY,
		SCQ_MUX_TEMP, 8'h08};
	localparam logic [2:0] GAINS[5] = '{3'h5, SCQ_GAIN_ONE, SCQ_GAIN_THIRD, SCQ_GAIN_ONE, 3'h5};
	localparam logic [3:0] TAGS[5] = '{4'hf, 4'he, 4'hd, 4'hc, 4'h0};
	localparam logic [23:0] GAPS[3] = '{24'h12c, 24'h100, 24'h00a};
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic dmclkTick = 1'b0;
	logic regWrEn = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [23:0] regWrData = 24'h0;
	logic startScan = 1'b0;
	logic continuous = 1'b0;
	logic [2:0] gainSel = 3'h5;
	logic [1:0] dataFormat = SCQ_FMT_TAGGED;
	logic [1:0] div = 2'h0;
	logic [23:0] regRdData, convData, dataOut;
	logic convDone, convStart, shortToGround, dataReady, scanActive;
	logic [7:0] muxCode;
	logic [2:0] gainCode;
	logic [1:0] adcModeInt;
	int errCount = 0;
	int comparisons = 0;
	int cyc = 0;
	int shutCnt = 0;
	int lastShut = 0;

	scq_conv_model #(.LAT(6)) conv_u (.mclk, .rst_n, .convStart, .muxCode, .convDone, .convData);
	scq_scan_sequencer dut_u (
		.mclk, .rst_n, .dmclkTick, .regWrEn, .regAddr, .regWrData, .regRdData, .startScan,
		.continuous, .gainSel, .dataFormat, .convDone, .convData, .convStart, .muxCode,
		.gainCode, .shortToGround, .adcModeInt, .dataOut, .dataReady, .scanActive
	);

	always #2 mclk = ~mclk;
	// Decimated clock: one tick every four cycles
	always @(negedge mclk) begin
		div <= div + 2'h1;
		dmclkTick <= (div == 2'h3);
	end
	// Sampled on the falling edge so the registered mode has settled
	always @(negedge mclk) begin
		cyc++;
		if (adcModeInt === SCQ_MODE_SHUT) begin
			shutCnt++;
			lastShut = cyc;
		end
	end

	task automatic results();
		$display("comparisons %0d, mismatches %0d", comparisons, errCount);
		if (errCount == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [23:0] exp, input logic [23:0] got);
		comparisons++;
		if (got !== exp) begin
			errCount++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic inRange(input string nm, input int lo, input int hi, input int got);
		comparisons++;
		if (got < lo || got > hi) begin
			errCount++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [23:0] d);
		@(negedge mclk);
		regWrEn = 1'b1;
		regAddr = a;
		regWrData = d;
		@(negedge mclk);
		regWrEn = 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [23:0] v);
		@(negedge mclk);
		regAddr = a;
		#1 v = regRdData;
	endtask
	task automatic start();
		@(negedge mclk);
		startScan = 1'b1;
		@(negedge mclk);
		startScan = 1'b0;
	endtask
	// Counts falling edges until convStart (sel 0) or dataReady (sel 1) is seen
	task automatic waitSig(input int sel, input int lim, output int n);
		n = 0;
		while ((sel == 0 ? convStart : dataReady) !== 1'b1) begin
			@(negedge mclk);
			n++;
			if (n > lim) begin
				errCount++;
				$display("MISMATCH wait expected event seen timeout");
				results();
			end
		end
	endtask

	initial begin
		int n;
		int s;
		logic [23:0] v;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		rst_n = 1'b1;
		rd(SCQ_ADDR_SCAN, v);
		check("scanReset", SCQ_SCAN_RST, v);
		wr(SCQ_ADDR_TIMER, 24'hffffff);
		wr(4'h3, 24'h123456);
		rd(SCQ_ADDR_TIMER, v);
		check("timerMax", 24'hffffff, v);
		rd(4'h3, v);
		check("unmapped", 24'h0, v);
		$display("test registers done");
		wr(SCQ_ADDR_SCAN, 24'h10f001);
		start();
		for (int i = 0; i < 5; i++) begin
			waitSig(0, 3000, n);
			if (i == 0) inRange("firstStart", 0, 0, n);
			check("mux", MUXS[i], muxCode);
			check("gain", GAINS[i], gainCode);
			check("short", i == 0, shortToGround);
			waitSig(1, 3000, n);
			check("tag", TAGS[i], dataOut[23:20]);
			// Raw result must come through: the host, not the block, cancels offset
			check("data", {TAGS[i], 12'h5a5, MUXS[i]}, dataOut);
			if (i < 4) begin
				check("muxNext", MUXS[i + 1], muxCode);
				@(negedge mclk);
				check("delayMode", SCQ_MODE_STBY, adcModeInt);
				rd(SCQ_ADDR_SETUP, v);
				check("modeRead", 24'h3, v[1:0]);
			end
		end
		repeat (4) @(negedge mclk);
		check("idle", 24'h0, scanActive);
		check("gainIdle", 3'h5, gainCode);
		rd(SCQ_ADDR_SCAN, v);
		check("scanKept", 24'h10f001, v);
		$display("test monitor channels done");
		for (int d = 0; d < 8; d++) begin
			wr(SCQ_ADDR_SCAN, {1'b0, 3'(d), 20'h0c000});
			start();
			waitSig(1, 3000, n);
			waitSig(0, 3000, n);
			s = (d == 0) ? 0 : 8 << (d - 1);
			inRange("delay", 4 * s - 4, 4 * s + 4, n);
			waitSig(1, 3000, n);
			repeat (4) @(negedge mclk);
		end
		$display("test intra-cycle delay done");
		dataFormat = 2'h0;
		foreach (GAPS[g]) begin
			wr(SCQ_ADDR_TIMER, GAPS[g]);
			wr(SCQ_ADDR_SCAN, 24'h000001);
			continuous = 1'b1;
			start();
			s = shutCnt;
			waitSig(1, 3000, n);
			repeat (20) @(negedge mclk);
			rd(SCQ_ADDR_SETUP, v);
			check("gapRead", 24'h3, v[1:0]);
			waitSig(0, 3000, n);
			inRange("gap", 4 * GAPS[g] - 4, 4 * GAPS[g] + 4, n + 21);
			check("shut", GAPS[g] > 256, shutCnt > s);
			if (GAPS[g] > 256) inRange("wake", 1018, 1032, cyc - lastShut);
			continuous = 1'b0;
			waitSig(1, 3000, n);
			check("untagged", 24'h05a508, dataOut);
			repeat (4) @(negedge mclk);
		end
		$display("test inter-cycle gap done");
		results();
	end
endmodule
